// ---- hw/dmc_link_capture.v ----
// link sampler: synchronises the command pins, finds link clock rising edges
// and assembles broadside or two-half multiplexed commands
// assumes the pins come from outside the hclk domain
`timescale 1ns/1ps
`include "dmc_regs.vh"

module dmc_link_capture (
  input wire hclk,
  input wire hresetn,
  input wire mux_mode,
  input wire link_ck,
  input wire cs_n,
  input wire we_n,
  input wire ref_n,
  input wire [19:0] addr_pin,
  input wire [3:0] ba_pin,
  output reg ck_rise_reg,
  output reg cmd_valid_reg,
  output reg [1:0] cmd_code_reg,
  output reg [3:0] cmd_ba_reg,
  output reg [19:0] cmd_addr_reg
);

  reg [26:0] meta_reg;
  reg [26:0] sync_reg;
  reg ck_meta_reg;
  reg ck_sync_reg;
  reg ck_old_reg;
  reg half_reg;
  wire ck_rise;

  ////////////////////////////////////////////////////////////////
  // two-flop synchronisers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 27'h7FFFFFF;
      sync_reg <= 27'h7FFFFFF;
      ck_meta_reg <= 1'b0;
      ck_sync_reg <= 1'b0;
      ck_old_reg <= 1'b0;
    end else begin
      meta_reg <= {cs_n, we_n, ref_n, ba_pin, addr_pin};
      sync_reg <= meta_reg;
      ck_meta_reg <= link_ck;
      ck_sync_reg <= ck_meta_reg;
      ck_old_reg <= ck_sync_reg;
    end
  end

  assign ck_rise = ck_sync_reg & ~ck_old_reg;

  ////////////////////////////////////////////////////////////////
  // command assembly
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_rise_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_code_reg <= 2'h3;
      cmd_ba_reg <= 4'h0;
      cmd_addr_reg <= 20'h00000;
      half_reg <= 1'b0;
    end else begin
      ck_rise_reg <= ck_rise;
      cmd_valid_reg <= 1'b0;
      if (ck_rise) begin
        if (half_reg) begin
          // second half: upper address bits on the low pins, see [RULE_01]
          cmd_addr_reg[19:`DMC_HALF_PINS] <= sync_reg[8:0];
          cmd_valid_reg <= 1'b1;
          half_reg <= 1'b0;
        end else if (!sync_reg[26]) begin
          // command and bank travel with the first half, see [RULE_03]
          cmd_code_reg <= sync_reg[25:24];
          cmd_ba_reg <= sync_reg[23:20];
          if (mux_mode) begin
            cmd_addr_reg <= {9'h000, sync_reg[10:0]};
            half_reg <= 1'b1;
          end else begin
            // broadside: all twenty pins in one cycle, see [RULE_02]
            cmd_addr_reg <= sync_reg[19:0];
            cmd_valid_reg <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ---- hw/dmc_regs.vh ----
// constants of the mode, termination and calibration block
// assumes inclusion by bare name from the design files
`ifndef DMC_REGS_VH
`define DMC_REGS_VH

// bus offsets
`define DMC_OFS_MODE_FIRST 8'h00
`define DMC_OFS_MODE_SECOND 8'h04
`define DMC_OFS_MODE_THIRD 8'h08
`define DMC_OFS_STATUS 8'h0C
`define DMC_OFS_CTRL 8'h10
`define DMC_OFS_REFRESH 8'h14

// mode_reg_first fields
`define DMC_F_DLL_EN 8
`define DMC_F_ADDR_MUX 9
// mode_reg_second fields
`define DMC_F_DRIVE_LO 0
`define DMC_F_TERM_LO 2
`define DMC_F_DLL_RST 5
`define DMC_F_CAL_SHORT 6
`define DMC_F_CAL_GO 7
`define DMC_F_REF_MULTI 8
`define DMC_F_BURST_LO 9

// field encodings
`define DMC_DRIVE_40 2'h0
`define DMC_DRIVE_60 2'h1
`define DMC_TERM_OFF 3'h0
`define DMC_TERM_40 3'h1
`define DMC_TERM_60 3'h2
`define DMC_TERM_120 3'h3
`define DMC_BURST_2 2'h0
`define DMC_BURST_4 2'h1
`define DMC_BURST_8 2'h2

// reset values
`define DMC_RST_MODE 20'h00000
`define DMC_RST_CTRL 1'h0

// command codes from the pins {we_n, ref_n}
`define DMC_CMD_MODE_SET 2'h0
`define DMC_CMD_WRITE 2'h1
`define DMC_CMD_REFRESH 2'h2
`define DMC_CMD_READ 2'h3

// timing counts in link clock cycles
`define DMC_DLL_LOCK_CYC 12'd512
`define DMC_INIT_CAL_CYC 12'd512
`define DMC_OPER_CAL_CYC 12'd256
`define DMC_SHORT_CAL_CYC 12'd64

// address pins used per half in multiplexed mode
`define DMC_HALF_PINS 11
`define DMC_REF_MAX_BANKS 5'd4

`endif

// ---- hw/dmc_tick_timer.v ----
// down counter advanced by a one-cycle tick enable
// assumes start and tick are on hclk
`timescale 1ns/1ps

module dmc_tick_timer #(
  parameter W = 12
) (
  input wire hclk,
  input wire hresetn,
  input wire start,
  input wire [W-1:0] load,
  input wire tick,
  output reg busy_reg,
  output reg done_reg
);

  reg [W-1:0] count_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= {W{1'b0}};
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        count_reg <= load;
        busy_reg <= 1'b1;
      end else if (busy_reg && tick) begin
        if (count_reg <= {{(W-1){1'b0}}, 1'b1}) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          count_reg <= {W{1'b0}};
        end else begin
          count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

// ---- hw/dmc_top.v ----
// mode register, termination, dll reset and impedance calibration block
// assumes an ahb-lite master on hclk and a memory controller on the link pins
//
// Notes on behaviour
// [RULE_01] multiplexed bit set: address taken in two halves on two rising edges
// [RULE_02] multiplexed uses eleven pins per half, broadside twenty in one cycle
// [RULE_03] controller gives bank and command with first half, rest next edge
// [RULE_04] two bits pick forty or sixty ohm drive; forty after power-up
// [RULE_05] three-bit field picks termination off, forty, sixty or 120 ohm
// [RULE_06] data termination off while read data driven, back on after last beat
// [RULE_07] mask and data-clock inputs stay terminated whenever termination enabled
// [RULE_08] writing dll reset bit starts reset, bit clears itself afterwards
// [RULE_09] controller waits 512 clocks after dll reset before any read
// [RULE_10] one bit picks long or short calibration, another starts it
// [RULE_11] calibration start bit returns low by itself when sequence ends
// [RULE_12] controller keeps channel quiet during calibration, banks idle first
// [RULE_13] calibration pin current path off once calibration completes
// [RULE_14] controller may start calibration during dll lock interval
// [RULE_15] controller never overlaps calibrations sharing one resistor
// [RULE_16] long calibration gets init interval during init, operational after
// [RULE_17] refresh bit high: multibank refresh, else single bank on bank pins
// [RULE_18] multibank: address pin i picks bank i, four banks at most
// [RULE_19] two bits set burst length of two, four or eight beats
// [RULE_20] address width shrinks with burst length, eight illegal in wide config
// [RULE_21] data written under an older burst length may read back wrong
// [RULE_22] controller drives upper bank pins and reserved address pins low
// [RULE_23] controller follows every dll enable with a dll reset
// [RULE_24] mode set only with all banks idle and no burst running
// [RULE_25] controller waits mode set cycle time after each mode set
// [RULE_26] field encodings fixed here and shared with controller models
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "dmc_regs.vh"

module dmc_top #(
  parameter WIDE_CFG = 0
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire link_ck,
  input wire cs_n,
  input wire we_n,
  input wire ref_n,
  input wire [19:0] addr_pin,
  input wire [3:0] ba_pin,
  input wire read_drive,
  output reg read_cmd_reg,
  output reg write_cmd_reg,
  output reg [3:0] cmd_bank_reg,
  output reg [19:0] cmd_addr_reg,
  output reg refresh_cmd_reg,
  output reg [15:0] refresh_banks_reg,
  output reg drive_60_reg,
  output reg [2:0] term_code_reg,
  output reg dq_term_on_reg,
  output reg mask_clk_term_on_reg,
  output reg dll_reset_busy_reg,
  output reg cal_busy_reg,
  output reg cal_pin_current_reg,
  output reg [3:0] burst_beats_reg,
  output reg [4:0] addr_width_reg
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CAL = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [19:0] mode_reg_first_reg;
  reg [19:0] mode_reg_second_reg;
  reg [19:0] mode_reg_third_reg;
  reg init_done_reg;
  reg burst_changed_reg;
  reg burst_illegal_reg;
  reg refresh_overflow_reg;
  reg dll_start_reg;
  reg cal_start_reg;
  reg [11:0] cal_load_reg;
  reg [2:0] cal_state_reg;
  reg [2:0] cal_state_next;
  reg bus_wr_reg;
  reg [7:0] bus_addr_reg;
  reg [31:0] rd_next;
  wire ck_rise;
  wire cmd_valid;
  wire [1:0] cmd_code;
  wire [3:0] cmd_ba;
  wire [19:0] cmd_addr;
  wire dll_busy;
  wire cal_busy;
  wire cal_done;
  wire [1:0] burst_sel;
  wire [19:0] addr_mask;
  wire bus_take;
  wire status_clr;

  ////////////////////////////////////////////////////////////////
  // helpers
  function [4:0] ones16;
    input [15:0] v;
    integer i;
    begin
      ones16 = 5'd0;
      for (i = 0; i < 16; i = i + 1) begin
        ones16 = ones16 + {4'h0, v[i]};
      end
    end
  endfunction

  function [4:0] width_of;
    input [1:0] bl;
    input wide;
    begin
      case (bl)
        `DMC_BURST_2: width_of = wide ? 5'd19 : 5'd20;
        `DMC_BURST_4: width_of = wide ? 5'd18 : 5'd19;
        `DMC_BURST_8: width_of = wide ? 5'd0 : 5'd18;
        default: width_of = 5'd0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // link capture and timers
  dmc_link_capture u_capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .mux_mode(mode_reg_first_reg[`DMC_F_ADDR_MUX]),
    .link_ck(link_ck),
    .cs_n(cs_n),
    .we_n(we_n),
    .ref_n(ref_n),
    .addr_pin(addr_pin),
    .ba_pin(ba_pin),
    .ck_rise_reg(ck_rise),
    .cmd_valid_reg(cmd_valid),
    .cmd_code_reg(cmd_code),
    .cmd_ba_reg(cmd_ba),
    .cmd_addr_reg(cmd_addr)
  );

  dmc_tick_timer #(.W(12)) u_dll_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(dll_start_reg),
    .load(`DMC_DLL_LOCK_CYC),
    .tick(ck_rise),
    .busy_reg(dll_busy),
    .done_reg()
  );

  dmc_tick_timer #(.W(12)) u_cal_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(cal_start_reg),
    .load(cal_load_reg),
    .tick(ck_rise),
    .busy_reg(cal_busy),
    .done_reg(cal_done)
  );

  assign burst_sel = mode_reg_second_reg[`DMC_F_BURST_LO+1:`DMC_F_BURST_LO];
  assign addr_mask = ~(20'hFFFFF << width_of(burst_sel, WIDE_CFG != 0));
  assign bus_take = hsel & htrans[1] & hready;
  assign status_clr = bus_wr_reg && (bus_addr_reg == `DMC_OFS_STATUS);

  ////////////////////////////////////////////////////////////////
  // mode registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg_first_reg <= `DMC_RST_MODE;
      mode_reg_second_reg <= `DMC_RST_MODE; // see [RULE_04]
      mode_reg_third_reg <= `DMC_RST_MODE;
      dll_start_reg <= 1'b0;
    end else begin
      dll_start_reg <= 1'b0;
      if (cmd_valid && cmd_code == `DMC_CMD_MODE_SET) begin
        case (cmd_ba[1:0])
          2'h0: mode_reg_first_reg <= cmd_addr;
          2'h1: mode_reg_second_reg <= cmd_addr;
          2'h2: mode_reg_third_reg <= cmd_addr;
          default: mode_reg_third_reg <= mode_reg_third_reg;
        endcase
      end else begin
        if (mode_reg_second_reg[`DMC_F_DLL_RST]) begin
          // self-clearing once the reset is launched, see [RULE_08]
          mode_reg_second_reg[`DMC_F_DLL_RST] <= 1'b0;
          dll_start_reg <= 1'b1;
        end
        if (cal_done) begin
          mode_reg_second_reg[`DMC_F_CAL_GO] <= 1'b0; // see [RULE_11]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // calibration sequencer
  always @* begin
    cal_state_next = cal_state_reg;
    case (cal_state_reg)
      ST_IDLE: begin
        if (mode_reg_second_reg[`DMC_F_CAL_GO] && !cmd_valid) begin
          cal_state_next = ST_CAL; // see [RULE_10]
        end
      end
      ST_CAL: begin
        if (cal_done) begin
          cal_state_next = ST_DONE;
        end
      end
      ST_DONE: cal_state_next = ST_IDLE;
      default: cal_state_next = ST_IDLE;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cal_state_reg <= ST_IDLE;
      cal_start_reg <= 1'b0;
      cal_load_reg <= 12'h000;
    end else begin
      cal_state_reg <= cal_state_next;
      cal_start_reg <= (cal_state_reg == ST_IDLE) && (cal_state_next == ST_CAL);
      if (mode_reg_second_reg[`DMC_F_CAL_SHORT]) begin
        cal_load_reg <= `DMC_SHORT_CAL_CYC; // see [RULE_10]
      end else if (init_done_reg) begin
        cal_load_reg <= `DMC_OPER_CAL_CYC; // see [RULE_16]
      end else begin
        cal_load_reg <= `DMC_INIT_CAL_CYC; // see [RULE_16]
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // command outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_cmd_reg <= 1'b0;
      write_cmd_reg <= 1'b0;
      refresh_cmd_reg <= 1'b0;
      cmd_bank_reg <= 4'h0;
      cmd_addr_reg <= 20'h00000;
      refresh_banks_reg <= 16'h0000;
    end else begin
      read_cmd_reg <= cmd_valid && (cmd_code == `DMC_CMD_READ);
      write_cmd_reg <= cmd_valid && (cmd_code == `DMC_CMD_WRITE);
      refresh_cmd_reg <= 1'b0;
      if (cmd_valid) begin
        cmd_bank_reg <= cmd_ba;
        cmd_addr_reg <= cmd_addr & addr_mask; // see [RULE_20]
      end
      if (cmd_valid && cmd_code == `DMC_CMD_REFRESH) begin
        if (mode_reg_second_reg[`DMC_F_REF_MULTI]) begin
          // one bank per address pin, capped at four, see [RULE_18]
          if (ones16(cmd_addr[15:0]) <= `DMC_REF_MAX_BANKS) begin
            refresh_banks_reg <= cmd_addr[15:0]; // see [RULE_17]
            refresh_cmd_reg <= 1'b1;
          end
        end else begin
          refresh_banks_reg <= 16'h0001 << cmd_ba; // see [RULE_17]
          refresh_cmd_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // io settings
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_60_reg <= 1'b0;
      term_code_reg <= `DMC_TERM_OFF;
      dq_term_on_reg <= 1'b0;
      mask_clk_term_on_reg <= 1'b0;
      dll_reset_busy_reg <= 1'b0;
      cal_busy_reg <= 1'b0;
      cal_pin_current_reg <= 1'b0;
      burst_beats_reg <= 4'd2;
      addr_width_reg <= 5'd20;
    end else begin
      // see [RULE_04]
      drive_60_reg <= (mode_reg_second_reg[`DMC_F_DRIVE_LO+1:`DMC_F_DRIVE_LO] == `DMC_DRIVE_60);
      // codes above 120 ohm read as off, see [RULE_05]
      if (mode_reg_second_reg[`DMC_F_TERM_LO+2:`DMC_F_TERM_LO] <= `DMC_TERM_120) begin
        term_code_reg <= mode_reg_second_reg[`DMC_F_TERM_LO+2:`DMC_F_TERM_LO];
      end else begin
        term_code_reg <= `DMC_TERM_OFF;
      end
      dq_term_on_reg <= (term_code_reg != `DMC_TERM_OFF) && !read_drive; // see [RULE_06]
      mask_clk_term_on_reg <= (term_code_reg != `DMC_TERM_OFF); // see [RULE_07]
      dll_reset_busy_reg <= dll_busy | dll_start_reg;
      cal_busy_reg <= (cal_state_reg == ST_CAL);
      cal_pin_current_reg <= (cal_state_next == ST_CAL); // see [RULE_13]
      case (burst_sel)
        `DMC_BURST_4: burst_beats_reg <= 4'd4; // see [RULE_19]
        `DMC_BURST_8: burst_beats_reg <= 4'd8;
        default: burst_beats_reg <= 4'd2;
      endcase
      addr_width_reg <= width_of(burst_sel, WIDE_CFG != 0);
    end
  end

  ////////////////////////////////////////////////////////////////
  // status flags, hardware set wins over software clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_changed_reg <= 1'b0;
      burst_illegal_reg <= 1'b0;
      refresh_overflow_reg <= 1'b0;
    end else begin
      // old burst data not trusted after a change, see [RULE_21]
      if (cmd_valid && cmd_code == `DMC_CMD_MODE_SET && cmd_ba[1:0] == 2'h1 &&
          cmd_addr[`DMC_F_BURST_LO+1:`DMC_F_BURST_LO] != burst_sel) begin
        burst_changed_reg <= 1'b1;
      end else if (status_clr && hwdata[4]) begin
        burst_changed_reg <= 1'b0;
      end
      if (width_of(burst_sel, WIDE_CFG != 0) == 5'd0) begin
        burst_illegal_reg <= 1'b1; // see [RULE_20]
      end else if (status_clr && hwdata[5]) begin
        burst_illegal_reg <= 1'b0;
      end
      if (cmd_valid && cmd_code == `DMC_CMD_REFRESH && mode_reg_second_reg[`DMC_F_REF_MULTI] &&
          ones16(cmd_addr[15:0]) > `DMC_REF_MAX_BANKS) begin
        refresh_overflow_reg <= 1'b1; // see [RULE_18]
      end else if (status_clr && hwdata[6]) begin
        refresh_overflow_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  always @* begin
    rd_next = 32'h00000000;
    case (haddr[7:0])
      `DMC_OFS_MODE_FIRST: rd_next = {12'h000, mode_reg_first_reg};
      `DMC_OFS_MODE_SECOND: rd_next = {12'h000, mode_reg_second_reg};
      `DMC_OFS_MODE_THIRD: rd_next = {12'h000, mode_reg_third_reg};
      `DMC_OFS_STATUS: rd_next = {25'h0000000, refresh_overflow_reg, burst_illegal_reg,
                                  burst_changed_reg, dq_term_on_reg, cal_pin_current_reg,
                                  cal_busy_reg, dll_reset_busy_reg};
      `DMC_OFS_CTRL: rd_next = {31'h00000000, init_done_reg};
      `DMC_OFS_REFRESH: rd_next = {16'h0000, refresh_banks_reg};
      default: rd_next = 32'h00000000;
    endcase
    if (haddr[31:8] != 24'h000000) begin
      rd_next = 32'h00000000;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= 8'h00;
      init_done_reg <= `DMC_RST_CTRL;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      bus_wr_reg <= bus_take & hwrite & (haddr[31:8] == 24'h000000);
      if (bus_take) begin
        bus_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_next;
        end
      end
      if (bus_wr_reg && bus_addr_reg == `DMC_OFS_CTRL) begin
        init_done_reg <= hwdata[0]; // see [RULE_16]
      end
    end
  end

endmodule

// ---- tb/dmc_link_model.sv ----
// memory controller model driving the command pins
// assumes a free running link clock, pins change on its falling edge
`timescale 1ns/1ps

module dmc_link_model (
  output logic link_ck,
  output logic cs_n,
  output logic we_n,
  output logic ref_n,
  output logic [19:0] addr_pin,
  output logic [3:0] ba_pin
);
  initial begin
    link_ck = 1'b0;
    cs_n = 1'b1;
    {we_n, ref_n} = 2'h3;
    addr_pin = 20'h00000;
    ba_pin = 4'h0;
    #37;
    forever #200 link_ck = ~link_ck;
  end

  // one command, whole or in two halves
  task issue(input logic [1:0] code, input logic [3:0] ba, input logic [19:0] a, input logic mux);
    @(negedge link_ck);
    cs_n <= 1'b0;
    {we_n, ref_n} <= code;
    ba_pin <= ba;
    addr_pin <= mux ? {~a[19:11], a[10:0]} : a;
    if (mux) begin
      @(negedge link_ck);
      cs_n <= 1'b1;
      addr_pin <= {~addr_pin[19:9], a[19:11]};
    end
    @(negedge link_ck);
    cs_n <= 1'b1;
    {we_n, ref_n} <= 2'h3;
    ba_pin <= ~ba_pin;
    addr_pin <= ~addr_pin;
    repeat (3) @(negedge link_ck);
  endtask
endmodule

// ---- tb/dmc_top_assertions.sv ----
// checker for the mode, termination and calibration block
// assumes a bind onto dmc_top, all in the hclk domain
`timescale 1ns/1ps

module dmc_top_checker #(
  parameter WIDE_CFG = 0
) (
  input wire hclk,
  input wire hresetn,
  input wire read_drive,
  input wire refresh_cmd_reg,
  input wire [15:0] refresh_banks_reg,
  input wire [2:0] term_code_reg,
  input wire dq_term_on_reg,
  input wire mask_clk_term_on_reg,
  input wire dll_reset_busy_reg,
  input wire cal_busy_reg,
  input wire cal_pin_current_reg,
  input wire [3:0] burst_beats_reg,
  input wire [4:0] addr_width_reg
);
  reg [12:0] dll_cnt_reg;
  reg [12:0] cal_cnt_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dll_cnt_reg <= 13'h0000;
      cal_cnt_reg <= 13'h0000;
    end else begin
      dll_cnt_reg <= dll_reset_busy_reg ? dll_cnt_reg + 13'h0001 : 13'h0000;
      cal_cnt_reg <= cal_busy_reg ? cal_cnt_reg + 13'h0001 : 13'h0000;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  term_mask_a: assert property ($stable(term_code_reg) |->
    mask_clk_term_on_reg == (term_code_reg != 3'h0)) else $error("mask termination wrong");
  dq_off_a: assert property ((read_drive && term_code_reg != 3'h0) |=>
    !dq_term_on_reg) else $error("dq termination on during read");
  dq_on_a: assert property ((!read_drive && $stable(term_code_reg) && term_code_reg != 3'h0) |=>
    dq_term_on_reg) else $error("dq termination not back on");
  cal_pin_a: assert property ($fell(cal_busy_reg) |-> ##[0:1]
    !cal_pin_current_reg) else $error("cal pin current left on");
  cal_len_a: assert property ($fell(cal_busy_reg) |->
    cal_cnt_reg inside {[496:528], [2032:2064], [4080:4112]}) else $error("cal length wrong");
  dll_len_a: assert property ($fell(dll_reset_busy_reg) |->
    dll_cnt_reg inside {[4080:4112]}) else $error("dll lock length wrong");
  refresh_max_a: assert property (refresh_cmd_reg |-> ##[0:1]
    ($countones(refresh_banks_reg) inside {[1:4]})) else $error("refresh bank count wrong");
  beats_set_a: assert property (burst_beats_reg inside {4'h2, 4'h4, 4'h8})
    else $error("burst beats illegal");
  width_map_a: assert property ((addr_width_reg != 5'h00 && $stable(burst_beats_reg)) |->
    addr_width_reg == 21 - WIDE_CFG - $clog2(burst_beats_reg)) else $error("address width wrong");
endmodule

bind dmc_top dmc_top_checker #(.WIDE_CFG(WIDE_CFG)) u_dmc_top_checker (.hclk, .hresetn, .read_drive,
  .refresh_cmd_reg, .refresh_banks_reg, .term_code_reg, .dq_term_on_reg, .mask_clk_term_on_reg,
  .dll_reset_busy_reg, .cal_busy_reg, .cal_pin_current_reg, .burst_beats_reg, .addr_width_reg);

// ---- tb/tb_dmc_top.sv ----
// testbench for the mode, termination and calibration block
// assumes the link model on the pins
`timescale 1ns/1ps

module tb_dmc_top;
  logic hclk, hresetn, hwrite, read_drive, mux_on;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  wire hready;
  wire hresp, we_n, ref_n, cs_n, link_ck;
  wire [19:0] addr_pin, cmd_addr_reg;
  wire [3:0] ba_pin, cmd_bank_reg, burst_beats_reg;
  wire [15:0] refresh_banks_reg;
  wire [2:0] term_code_reg;
  wire [4:0] addr_width_reg;
  wire rd_p, wr_p, rf_p, drive_60_reg, dq_term_on_reg, mask_clk_term_on_reg;
  wire dll_reset_busy_reg, cal_busy_reg, cal_pin_current_reg;
  int mismatches = 0, total_checks = 0, rd_n = 0, wr_n = 0, rf_n = 0, n;

  dmc_top u_dmc_top (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hreadyout(hready), .hrdata, .hresp, .link_ck, .cs_n, .we_n, .ref_n, .addr_pin, .ba_pin, .read_drive,
    .read_cmd_reg(rd_p), .write_cmd_reg(wr_p), .cmd_bank_reg, .cmd_addr_reg, .refresh_cmd_reg(rf_p),
    .refresh_banks_reg, .drive_60_reg, .term_code_reg, .dq_term_on_reg, .mask_clk_term_on_reg,
    .dll_reset_busy_reg, .cal_busy_reg, .cal_pin_current_reg, .burst_beats_reg, .addr_width_reg);
  dmc_link_model u_dmc_link_model (.link_ck, .cs_n, .we_n, .ref_n, .addr_pin, .ba_pin);

  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    rd_n <= rd_n + (rd_p === 1'b1);
    wr_n <= wr_n + (wr_p === 1'b1);
    rf_n <= rf_n + (rf_p === 1'b1);
  end

  ////////////////////////////////////////////////////////////////
  task print_verdict;
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      print_verdict;
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  task ms(input logic [1:0] reg_sel, input logic [19:0] v);
    u_dmc_link_model.issue(2'h0, {2'h0, reg_sel}, v, mux_on);
  endtask
  task cmd(input logic [1:0] c, input logic [3:0] b, input logic [19:0] a);
    u_dmc_link_model.issue(c, b, a, mux_on);
  endtask
  task wait_clr(input bit dll);
    n = 0;
    while ((dll ? dll_reset_busy_reg : cal_busy_reg) !== 1'b0 && n < 6000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 6000) begin
      mismatches++;
      print_verdict;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  task t_reset;
    chk("drive", 0, drive_60_reg);
    chk("resp", 0, hresp);
    chk("beats", 2, burst_beats_reg);
    chk("width", 20, addr_width_reg);
    bus(1, 32'h00000000, 32'hFFFFFFFF);
    bus(0, 32'h00000000, 0);
    chk("mode first ro", 0, r);
    bus(0, 32'h00000020, 0);
    chk("unmapped", 0, r);
  endtask
  task t_fields;
    for (int i = 1; i < 4; i++) begin
      ms(1, 20'(i * 4 + 1));
      chk("term", i, term_code_reg);
      chk("mask term", 1, mask_clk_term_on_reg);
      chk("drive60", 1, drive_60_reg);
    end
    for (int i = 0; i < 3; i++) begin
      ms(1, 20'(i << 9));
      chk("beats", 2 << i, burst_beats_reg);
      chk("width", 20 - i, addr_width_reg);
    end
    ms(1, 20'h00600);
    chk("width bad", 0, addr_width_reg);
    bus(0, 32'h00000004, 0);
    chk("mode second", 32'h00000600, r);
    bus(0, 32'h0000000C, 0);
    chk("illegal flag", 32'h00000030, r & 32'h00000030);
  endtask
  task t_dq;
    ms(1, 20'h00004);
    @(posedge hclk) read_drive <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("dq term read", 0, dq_term_on_reg);
    chk("mask term read", 1, mask_clk_term_on_reg);
    read_drive <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("dq term after", 1, dq_term_on_reg);
  endtask
  task t_cmd;
    ms(1, 20'h00400);
    cmd(2'h3, 4'h5, 20'hFFFFF);
    chk("rd pulse", 1, rd_n);
    chk("rd bank", 5, cmd_bank_reg);
    chk("rd addr bl8", 32'h0003FFFF, cmd_addr_reg);
    ms(1, 20'h00000);
    cmd(2'h1, 4'hA, 20'hABCDE);
    chk("wr pulse", 1, wr_n);
    chk("wr addr", 32'h000ABCDE, cmd_addr_reg);
    ms(0, 20'h00200);
    mux_on = 1'b1;
    cmd(2'h3, 4'h3, 20'h5A5A5);
    chk("mux rd pulse", 2, rd_n);
    chk("mux addr", 32'h0005A5A5, cmd_addr_reg);
    chk("mux bank", 3, cmd_bank_reg);
    ms(0, 20'h00000);
    mux_on = 1'b0;
  endtask
  task t_dll_cal;
    ms(0, 20'h00100);
    ms(1, 20'h00020);
    bus(0, 32'h00000004, 0);
    chk("dll bit clear", 0, r);
    chk("dll busy", 1, dll_reset_busy_reg);
    ms(1, 20'h000C0);
    chk("cal busy", 1, cal_busy_reg);
    wait_clr(0);
    chk("cal pin", 0, cal_pin_current_reg);
    bus(0, 32'h00000004, 0);
    chk("cal go clear", 32'h00000040, r);
    wait_clr(1);
    bus(1, 32'h00000010, 32'h00000000);
    ms(1, 20'h00080);
    wait_clr(0);
    chk("long init len", 1, n > 3900 && n < 4110);
    bus(1, 32'h00000010, 32'h00000001);
    ms(1, 20'h00080);
    wait_clr(0);
    chk("long oper len", 1, n > 1850 && n < 2060);
  endtask
  task t_ref;
    ms(1, 20'h00000);
    cmd(2'h2, 4'h9, 20'h00000);
    chk("single ref", 32'h00000200, refresh_banks_reg);
    ms(1, 20'h00100);
    cmd(2'h2, 4'h0, 20'h08421);
    chk("multi ref", 32'h00008421, refresh_banks_reg);
    cmd(2'h2, 4'h0, 20'h0001F);
    chk("ref pulses", 2, rf_n);
    bus(0, 32'h00000014, 0);
    chk("ref reg", 32'h00008421, r);
    bus(0, 32'h0000000C, 0);
    chk("ref flag", 32'h00000040, r & 32'h00000040);
    bus(1, 32'h0000000C, 32'h00000070);
    bus(0, 32'h0000000C, 0);
    chk("ref flag clr", 0, r & 32'h00000040);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    read_drive = 1'b0;
    mux_on = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_fields;
    t_dq;
    t_cmd;
    t_dll_cal;
    t_ref;
    print_verdict;
  end
endmodule
